//--- core/flags_defs.svh
// Purpose: Offsets, field positions, reset values and timing for the flag block
// Assumes: 32-bit classic Wishbone, byte addresses on wb_adr_i[7:0]
// Notes: Definitions only
`ifndef FLAGS_DEFS_SVH
`define FLAGS_DEFS_SVH
`define A_CTRL 8'h00
`define A_SETVAL 8'h04
`define A_ASSIGN 8'h08
`define A_FLAGS 8'h0c
`define A_ISTAT 8'h10
`define A_ICLR 8'h14
`define A_IEN 8'h18
`define A_TLIM 8'h1c
`define A_CODE0 8'h20
`define A_RAMVAL 8'h38
`define A_NVVAL 8'h3c
`define B_NV_REQ 0
`define B_RAM_REQ 1
`define B_IX_REQ 2
`define SEL_W 5
`define SEL_NONE 5'h1f
`define AUX3_DEF 5'h00
`define AUX4_DEF 5'h01
`define ASSIGN_RST {`SEL_NONE, `SEL_NONE, `SEL_NONE, `AUX4_DEF, `AUX3_DEF}
`define IX_WORDS 3'h6
`define EV_W 5
`define CLK_NS 10
`define NV_WR_NS 200
`define NV_WR_CYC (((`NV_WR_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`endif

//--- core/flags_pkg.sv
// Purpose: Types shared by the flag block
// Assumes: Nothing beyond the defs header
// Notes: State encodings are written out
package flags_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01,
      ST_DONE = 2'b10
   } hs_st_t;
endpackage : flags_pkg

//--- core/remote_status_flags.sv
// Purpose: Drive-side status flags and write/instruction handshakes, Wishbone reachable
// Assumes: One clock, sync active-high reset, inputs synchronous to clk_i
// Notes: Request bits live in CTRL; flags show on ports and in FLAGS
// Overview of operation
// - A nonvolatile write request sets its done flag once both stores hold the value.
// - In sensorless modes a write also stores torque command or torque limit.
// - An instruction request sets its done flag after every code word is processed.
// - The two auxiliary output flags follow the functions their selectors choose.
// - The fault flag is 1 whenever a protective trip is present.
// - Station ready rises only after initial setting is complete.
// - A protective trip drives station ready to 0.
// - The three extra output flags carry nothing until their selectors assign one.
// - Up-to-frequency and overload alarm are fixed and never reassigned.
//
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "flags_defs.svh"
module remote_status_flags
   import flags_pkg::*;
(
   input wire logic clk_i,                  // 100 MHz clock
   input wire logic sys_rst_i,              // Sync reset, high
   input wire logic wb_cyc_i,               // Bus cycle
   input wire logic wb_stb_i,               // Strobe
   input wire logic wb_we_i,                // Write
   input wire logic [7:0] wb_adr_i,         // Byte address
   input wire logic [3:0] wb_sel_i,         // Byte lanes
   input wire logic [31:0] wb_dat_i,        // Write data
   output logic [31:0] wb_dat_o,            // Read data
   output logic wb_ack_o,                   // Ack
   input wire logic fault_i,                // Protective trip active
   input wire logic init_done_i,            // Initial setting finished
   input wire logic sensorless_i,           // Sensorless vector mode
   input wire logic torque_ctrl_i,          // 1 torque control, 0 speed
   input wire logic [15:0] func_i,          // Selectable output functions
   input wire logic up_to_freq_i,           // Frequency reached
   input wire logic overload_i,             // Overload warning
   output logic nv_write_done_flag_o,       // Nonvolatile write done
   output logic ram_write_done_o,           // Volatile write done
   output logic instr_exec_done_flag_o,     // Instruction done
   output logic fault_flag_o,               // Error status
   output logic station_ready_flag_o,       // Station ready
   output logic aux_output_flag_three_o,    // Reassignable flag 3
   output logic aux_output_flag_four_o,     // Reassignable flag 4
   output logic extra_output_flag_zero_o,   // Extra flag 0
   output logic extra_output_flag_one_o,    // Extra flag 1
   output logic extra_output_flag_two_o,    // Extra flag 2
   output logic up_to_frequency_o,          // Fixed flag
   output logic overload_alarm_o,           // Fixed flag
   output logic instr_strobe_o,             // One code word issued
   output logic [15:0] instr_code_o,        // Issued code word
   output logic irq_o                       // Level interrupt
);
   logic [2:0] ctrl_ff;
   logic [15:0] setval_ff;
   logic [15:0] tlim_ff;
   logic [24:0] assign_ff;
   logic [15:0] code_ff [0:5];
   logic [15:0] ram_freq_ff, ram_trq_ff, nv_freq_ff, nv_trq_ff;
   logic [7:0] nv_cnt_ff;
   logic [2:0] ix_idx_ff;
   hs_st_t nv_st_ff, ram_st_ff, ix_st_ff;
   logic [`EV_W-1:0] istat_ff, ien_ff, ev;
   logic fault_q_ff, ready_q_ff, nv_q_ff, ram_q_ff, ix_q_ff;
   logic wr, rd_hit;
   logic [31:0] nxt_dat;
   logic [31:0] wmask;

   // Pick a function bit; the none code leaves the flag low
   function automatic logic sel_fn(input logic [`SEL_W-1:0] s, input logic [15:0] v);
      sel_fn = s[`SEL_W-1] ? 1'b0 : v[s[3:0]];
   endfunction : sel_fn

   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // One-cycle ack per request; ack drops the cycle after
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      end
   end

   // Software-written configuration; lanes honoured, unmapped writes dropped
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl_ff <= 3'h0;
         setval_ff <= 16'h0000;
         tlim_ff <= 16'h0000;
         assign_ff <= `ASSIGN_RST;
         ien_ff <= '0;
      end else if (wr) begin
         unique case (wb_adr_i)
            `A_CTRL: if (wb_sel_i[0]) ctrl_ff <= wb_dat_i[2:0];
            `A_SETVAL: setval_ff <= (setval_ff & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
            `A_TLIM: tlim_ff <= (tlim_ff & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
            `A_ASSIGN: assign_ff <= (assign_ff & ~wmask[24:0]) | (wb_dat_i[24:0] & wmask[24:0]);
            `A_IEN: if (wb_sel_i[0]) ien_ff <= wb_dat_i[`EV_W-1:0];
            default: ;
         endcase
      end
   end

   // Instruction code words, one per aligned word
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < 6; i++) code_ff[i] <= 16'h0000;
      end else if (wr && wb_adr_i >= `A_CODE0 && wb_adr_i < `A_RAMVAL) begin
         code_ff[3'((wb_adr_i - `A_CODE0) >> 2)] <= wb_dat_i[15:0];
      end
   end

   // Volatile-only write: one cycle store, done held until request drops
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ram_st_ff <= ST_IDLE;
      end else begin
         unique case (ram_st_ff)
            ST_IDLE: if (ctrl_ff[`B_RAM_REQ]) ram_st_ff <= ST_DONE;
            ST_DONE: if (!ctrl_ff[`B_RAM_REQ]) ram_st_ff <= ST_IDLE;
            default: ram_st_ff <= ST_IDLE;
         endcase
      end
   end

   // Nonvolatile write: RAM at once, EEPROM after the program time
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         nv_st_ff <= ST_IDLE;
         nv_cnt_ff <= 8'h00;
      end else begin
         unique case (nv_st_ff)
            ST_IDLE: if (ctrl_ff[`B_NV_REQ]) begin
               nv_st_ff <= ST_BUSY;
               nv_cnt_ff <= 8'(`NV_WR_CYC);
            end
            ST_BUSY: begin
               nv_cnt_ff <= nv_cnt_ff - 8'h01;
               if (nv_cnt_ff == 8'h01) nv_st_ff <= ST_DONE;
            end
            ST_DONE: if (!ctrl_ff[`B_NV_REQ]) nv_st_ff <= ST_IDLE;
            default: nv_st_ff <= ST_IDLE;
         endcase
      end
   end

   // Stores; torque value or limit rides along only in sensorless modes
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ram_freq_ff <= 16'h0000;
         ram_trq_ff <= 16'h0000;
         nv_freq_ff <= 16'h0000;
         nv_trq_ff <= 16'h0000;
      end else begin
         if ((nv_st_ff == ST_IDLE && ctrl_ff[`B_NV_REQ]) ||
             (ram_st_ff == ST_IDLE && ctrl_ff[`B_RAM_REQ])) begin
            ram_freq_ff <= setval_ff;
            if (sensorless_i) ram_trq_ff <= torque_ctrl_i ? setval_ff : tlim_ff;
         end
         if (nv_st_ff == ST_BUSY && nv_cnt_ff == 8'h01) begin
            nv_freq_ff <= ram_freq_ff;
            if (sensorless_i) nv_trq_ff <= ram_trq_ff;
         end
      end
   end

   // Instruction words go out one per cycle, all of them before done
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ix_st_ff <= ST_IDLE;
         ix_idx_ff <= 3'h0;
         instr_strobe_o <= 1'b0;
         instr_code_o <= 16'h0000;
      end else begin
         instr_strobe_o <= 1'b0;
         unique case (ix_st_ff)
            ST_IDLE: if (ctrl_ff[`B_IX_REQ]) begin
               ix_st_ff <= ST_BUSY;
               ix_idx_ff <= 3'h0;
            end
            ST_BUSY: begin
               instr_strobe_o <= 1'b1;
               instr_code_o <= code_ff[ix_idx_ff];
               ix_idx_ff <= ix_idx_ff + 3'h1;
               if (ix_idx_ff == `IX_WORDS - 3'h1) ix_st_ff <= ST_DONE;
            end
            ST_DONE: if (!ctrl_ff[`B_IX_REQ]) ix_st_ff <= ST_IDLE;
            default: ix_st_ff <= ST_IDLE;
         endcase
      end
   end

   // Output flags from flops; fixed flags bypass every selector
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         nv_write_done_flag_o <= 1'b0;
         ram_write_done_o <= 1'b0;
         instr_exec_done_flag_o <= 1'b0;
         fault_flag_o <= 1'b0;
         station_ready_flag_o <= 1'b0;
         aux_output_flag_three_o <= 1'b0;
         aux_output_flag_four_o <= 1'b0;
         extra_output_flag_zero_o <= 1'b0;
         extra_output_flag_one_o <= 1'b0;
         extra_output_flag_two_o <= 1'b0;
         up_to_frequency_o <= 1'b0;
         overload_alarm_o <= 1'b0;
      end else begin
         nv_write_done_flag_o <= (nv_st_ff == ST_DONE) & ctrl_ff[`B_NV_REQ];
         ram_write_done_o <= (ram_st_ff == ST_DONE) & ctrl_ff[`B_RAM_REQ];
         instr_exec_done_flag_o <= (ix_st_ff == ST_DONE) & ctrl_ff[`B_IX_REQ];
         fault_flag_o <= fault_i;
         station_ready_flag_o <= init_done_i & ~fault_i;
         aux_output_flag_three_o <= sel_fn(assign_ff[4:0], func_i);
         aux_output_flag_four_o <= sel_fn(assign_ff[9:5], func_i);
         extra_output_flag_zero_o <= sel_fn(assign_ff[14:10], func_i);
         extra_output_flag_one_o <= sel_fn(assign_ff[19:15], func_i);
         extra_output_flag_two_o <= sel_fn(assign_ff[24:20], func_i);
         up_to_frequency_o <= up_to_freq_i;
         overload_alarm_o <= overload_i;
      end
   end

   // Rising edges of the ready, fault and three done flags are the interrupt events
   assign ev = {station_ready_flag_o & ~ready_q_ff, fault_flag_o & ~fault_q_ff,
                instr_exec_done_flag_o & ~ix_q_ff, nv_write_done_flag_o & ~nv_q_ff,
                ram_write_done_o & ~ram_q_ff};

   // Sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         istat_ff <= '0;
         {ready_q_ff, fault_q_ff, ix_q_ff, nv_q_ff, ram_q_ff} <= 5'h00;
      end else begin
         {ready_q_ff, fault_q_ff, ix_q_ff, nv_q_ff, ram_q_ff} <=
            {station_ready_flag_o, fault_flag_o, instr_exec_done_flag_o,
             nv_write_done_flag_o, ram_write_done_o};
         istat_ff <= (istat_ff & ~((wr && wb_adr_i == `A_ICLR && wb_sel_i[0]) ?
                     wb_dat_i[`EV_W-1:0] : 5'h00)) | ev;
      end
   end

   assign irq_o = |(istat_ff & ien_ff);

   // Read mux; unmapped and write-only offsets read zero
   always_comb begin
      nxt_dat = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (wb_adr_i)
         `A_CTRL: nxt_dat[2:0] = ctrl_ff;
         `A_SETVAL: nxt_dat[15:0] = setval_ff;
         `A_TLIM: nxt_dat[15:0] = tlim_ff;
         `A_ASSIGN: nxt_dat[24:0] = assign_ff;
         `A_FLAGS: nxt_dat[11:0] = {overload_alarm_o, up_to_frequency_o,
            extra_output_flag_two_o, extra_output_flag_one_o, extra_output_flag_zero_o,
            aux_output_flag_four_o, aux_output_flag_three_o, station_ready_flag_o,
            fault_flag_o, instr_exec_done_flag_o, ram_write_done_o, nv_write_done_flag_o};
         `A_ISTAT: nxt_dat[`EV_W-1:0] = istat_ff;
         `A_IEN: nxt_dat[`EV_W-1:0] = ien_ff;
         `A_RAMVAL: nxt_dat = {ram_trq_ff, ram_freq_ff};
         `A_NVVAL: nxt_dat = {nv_trq_ff, nv_freq_ff};
         default: rd_hit = 1'b0;
      endcase
      if (!rd_hit && wb_adr_i >= `A_CODE0 && wb_adr_i < `A_RAMVAL)
         nxt_dat[15:0] = code_ff[3'((wb_adr_i - `A_CODE0) >> 2)];
   end

   // Read data registered with the ack
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) wb_dat_o <= 32'h0000_0000;
      else wb_dat_o <= nxt_dat;
   end

   a_nv_done_cause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(nv_write_done_flag_o) |-> ctrl_ff[`B_NV_REQ] && nv_freq_ff == ram_freq_ff)
      else $error("nv done without both stores");
   a_nv_done_drop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ctrl_ff[`B_NV_REQ] |=> !nv_write_done_flag_o)
      else $error("nv done held after request dropped");
   a_torque_store: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (nv_st_ff == ST_IDLE && ctrl_ff[`B_NV_REQ] && sensorless_i)
      |=> ram_trq_ff == ($past(torque_ctrl_i) ? $past(setval_ff) : $past(tlim_ff)))
      else $error("torque value not stored");
   a_ix_done_all: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(instr_exec_done_flag_o) |-> ix_idx_ff == `IX_WORDS && ctrl_ff[`B_IX_REQ])
      else $error("instruction done early");
   a_aux_select: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !sys_rst_i |=> aux_output_flag_three_o == $past(!assign_ff[4] && func_i[assign_ff[3:0]]))
      else $error("aux flag three wrong source");
   a_fault_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      fault_i |=> fault_flag_o)
      else $error("fault flag missing");
   a_ready_init: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !init_done_i |=> !station_ready_flag_o)
      else $error("ready before initial setting");
   a_ready_fault: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      fault_i |=> !station_ready_flag_o && fault_flag_o)
      else $error("ready high during fault");
   a_extra_none: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      assign_ff[14:10] == `SEL_NONE |=> !extra_output_flag_zero_o)
      else $error("unassigned extra flag active");
   a_fixed_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !sys_rst_i |=> up_to_frequency_o == $past(up_to_freq_i) &&
      overload_alarm_o == $past(overload_i))
      else $error("fixed flag reassigned");
endmodule : remote_status_flags

//--- testbench/net_master.sv
// Purpose: Field-network master model that reaches the flag block over Wishbone
// Assumes: Classic single cycles; ack is sampled on the rising edge
// Notes: hang is set when a wait runs out or the slave was not ready
`timescale 1ns/1ps
`include "flags_defs.svh"
module net_master (
   input wire logic clk_i,            // Clock
   input wire logic wb_ack_i,         // Ack from slave
   input wire logic [31:0] wb_dat_i,  // Read data
   output logic wb_cyc_o,             // Cycle
   output logic wb_stb_o,             // Strobe
   output logic wb_we_o,              // Write
   output logic [7:0] wb_adr_o,       // Byte address
   output logic [3:0] wb_sel_o,       // Byte lanes
   output logic [31:0] wb_dat_o       // Write data
);
   logic hang = 1'b0;
   // Bus idle at time zero
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'h0;
   end
   // One transfer; request held until ack is seen, then released for a cycle
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
         output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'hf;
      wb_dat_o <= dat;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_i !== 1'b1 && n < 50);
      rdat = wb_dat_i;
      if (n >= 50) hang = 1'b1;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
   endtask : xfer
   // Poll the flag word until bit b reads v, under a bound
   task automatic poll(input int b, input logic v);
      logic [31:0] r;
      int n;
      n = 0;
      do begin
         xfer(1'b0, `A_FLAGS, 32'h0, r);
         n++;
      end while (r[b] !== v && n < 100);
      if (n >= 100) hang = 1'b1;
   endtask : poll
   // Full request: check ready, value (not for instructions), raise, wait done, drop, wait clear
   task automatic hs(input int b, input logic [15:0] val);
      logic [31:0] r;
      xfer(1'b0, `A_FLAGS, 32'h0, r);
      if (r[4] !== 1'b1) hang = 1'b1;
      if (b != `B_IX_REQ) xfer(1'b1, `A_SETVAL, {16'h0, val}, r);
      xfer(1'b1, `A_CTRL, 32'h1 << b, r);
      poll(b, 1'b1);
      xfer(1'b1, `A_CTRL, 32'h0, r);
      poll(b, 1'b0);
   endtask : hs
endmodule : net_master

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the remote status flag block
// Assumes: Flags lag their sources by one registered cycle
// Notes: All register traffic goes through the master model
`timescale 1ns/1ps
`include "flags_defs.svh"
module testbench;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, r;
   logic fault_i = 1'b0, init_done_i = 1'b0, sensorless_i = 1'b0, torque_ctrl_i = 1'b0;
   logic up_to_freq_i = 1'b0, overload_i = 1'b0;
   logic [15:0] func_i = 16'ha5c3;
   logic [15:0] instr_code_o, code_q[$];
   logic nv_write_done_flag_o, ram_write_done_o, instr_exec_done_flag_o, fault_flag_o;
   logic station_ready_flag_o, aux_output_flag_three_o, aux_output_flag_four_o;
   logic extra_output_flag_zero_o, extra_output_flag_one_o, extra_output_flag_two_o;
   logic up_to_frequency_o, overload_alarm_o, instr_strobe_o, irq_o;
   int error_cnt = 0;
   int total_checks = 0;
   remote_status_flags i_remote_status_flags (.clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fault_i, .init_done_i,
      .sensorless_i, .torque_ctrl_i, .func_i, .up_to_freq_i, .overload_i, .nv_write_done_flag_o,
      .ram_write_done_o, .instr_exec_done_flag_o, .fault_flag_o, .station_ready_flag_o,
      .aux_output_flag_three_o, .aux_output_flag_four_o, .extra_output_flag_zero_o,
      .extra_output_flag_one_o, .extra_output_flag_two_o, .up_to_frequency_o,
      .overload_alarm_o, .instr_strobe_o, .instr_code_o, .irq_o);
   net_master u_master (.clk_i, .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
      .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
      .wb_dat_o(wb_dat_i));
   // 100 MHz clock
   initial forever #5 clk_i = ~clk_i;
   // Collect every issued code word in order
   always @(posedge clk_i) if (instr_strobe_o === 1'b1) code_q.push_back(instr_code_o);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_master.xfer(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      u_master.xfer(1'b0, a, 32'h0, r);
   endtask : rd
   task automatic results;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clk_i);
      error_cnt++;
      $display("[ERR] watchdog expected finish seen timeout");
      results();
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("ready before init", 32'h0, station_ready_flag_o);
      chk("extras unassigned", 32'h0, {extra_output_flag_two_o, extra_output_flag_one_o,
         extra_output_flag_zero_o});
      chk("aux defaults", 32'h3, {aux_output_flag_four_o, aux_output_flag_three_o});
      init_done_i <= 1'b1;
      up_to_freq_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("ready after init", 32'h1, station_ready_flag_o);
      // Reassign every selectable flag; fixed flags must still follow their sources
      wr(`A_ASSIGN, 32'hf4a0e2);
      for (int k = 0; k < 2; k++) begin
         func_i <= k ? 16'h5a3c : 16'ha5c3;
         overload_i <= k[0];
         up_to_freq_i <= ~k[0];
         repeat (2) @(posedge clk_i);
         chk("assigned flags", {func_i[15], func_i[9], func_i[8], func_i[7], func_i[2]},
            {extra_output_flag_two_o, extra_output_flag_one_o, extra_output_flag_zero_o,
            aux_output_flag_four_o, aux_output_flag_three_o});
         chk("fixed flags", {overload_i, up_to_freq_i},
            {overload_alarm_o, up_to_frequency_o});
      end
      // Volatile store in torque control, then both stores in speed control
      sensorless_i <= 1'b1;
      torque_ctrl_i <= 1'b1;
      u_master.hs(`B_RAM_REQ, 16'h1234);
      rd(`A_RAMVAL);
      chk("ram torque cmd", 32'h12341234, r);
      wr(`A_TLIM, 32'h0777);
      torque_ctrl_i <= 1'b0;
      u_master.hs(`B_NV_REQ, 16'h2345);
      rd(`A_NVVAL);
      chk("nv torque limit", 32'h07772345, r);
      chk("nv done cleared", 32'h0, nv_write_done_flag_o);
      // Outside sensorless modes the torque store must keep its old value
      sensorless_i <= 1'b0;
      u_master.hs(`B_RAM_REQ, 16'h3456);
      rd(`A_RAMVAL);
      chk("torque kept outside sensorless", 32'h07773456, r);
      // Six code words must be issued in order before done
      for (int k = 0; k < 6; k++) wr(`A_CODE0 + 8'(4 * k), {16'h0, 16'h0100 + 16'(k)});
      u_master.hs(`B_IX_REQ, 16'h0);
      chk("code count", 32'h6, code_q.size());
      for (int k = 0; k < 6; k++) chk("code word", 32'h0100 + k, {16'h0, code_q[k]});
      rd(`A_ISTAT);
      chk("done events", 32'h7, r & 32'h7);
      // Trip: fault up, ready down, interrupt raised, masked and cleared
      wr(`A_ICLR, 32'h1f);
      wr(`A_IEN, 32'h08);
      fault_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("fault flag", 32'h1, fault_flag_o);
      chk("ready on trip", 32'h0, station_ready_flag_o);
      chk("irq raised", 32'h1, irq_o);
      wr(`A_IEN, 32'h0);
      chk("irq masked", 32'h0, irq_o);
      wr(`A_IEN, 32'h08);
      wr(`A_ICLR, 32'h08);
      chk("irq cleared", 32'h0, irq_o);
      fault_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("ready after trip", 32'h1, station_ready_flag_o);
      wr(8'h40, 32'hffff);
      rd(8'h40);
      chk("unmapped read", 32'h0, r);
      chk("master waits", 32'h0, u_master.hang);
      results();
   end
endmodule : testbench
